// ---- src/clkfo_pkg.sv ----
// Constants for the clock fan-out control block: I2C address, byte layout, reset values.
// Assumes a single 100 MHz system clock and that all pins are synchronised before use.
package clkfo_pkg;
  localparam int NUM_PAIRS = 14;
  localparam int NUM_SHARED = 6;
  localparam int SYNC_W = 5;
  // Synchroniser reset levels match the idle pins, SCL and SDA high, so no false edge follows reset.
  localparam logic [4:0] SYNC_IDLE = 5'h03;
  // Seven-bit slave address, most significant bit first: 1101001.
  localparam logic [6:0] I2C_ADDR = 7'h69;
  localparam logic [7:0] BYTE_COUNT_RESET = 8'h09;
  localparam logic [4:0] REG_IDX_CTRL_A = 5'h06;
  localparam logic [4:0] REG_IDX_CTRL_B = 5'h07;
  // Write transfers carry a command byte and a count byte before data index 0.
  localparam logic [4:0] WR_DATA_OFS = 5'h02;
  // Read transfers carry the count byte before data index 0.
  localparam logic [4:0] RD_DATA_OFS = 5'h01;
  localparam logic [4:0] POS_MAX = 5'h1f;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int A_SEL_BIT = 7;
  localparam int A_SDR_DRV_BIT = 6;
  localparam int A_DDR_DRV_BIT = 5;
  localparam int A_PAIR1213_BIT = 4;
  localparam int A_PAIR8_BIT = 0;
  localparam int B_PAIR6_BIT = 6;
  localparam logic [6:0] CTRL_A_RESET = 7'h1f;
  localparam logic [7:0] CTRL_B_RESET = 8'hff;
  localparam logic [7:0] READ_FILL = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_RX,
    ST_ACK_RX,
    ST_TX,
    ST_ACK_TX
  } clkfo_state_t;
endpackage : clkfo_pkg

// ---- src/clkfo_sync.sv ----
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes the inputs are quasi-static or slow compared with the clock.
`timescale 1ns/10ps
module clkfo_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_out <= sync_d;
    end
  end
endmodule : clkfo_sync

// ---- src/clkfo_out_gate.sv ----
// Output stage: per-pair gating, mode-dependent complement and power-down enables.
// Assumes the reference and the level inputs are already synchronised to clk.
`timescale 1ns/10ps
module clkfo_out_gate #(
  parameter int NP = 14,
  parameter int NS = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ref_s,
  input wire logic pd_n_s,
  input wire logic sdr_mode,
  input wire logic [NP-1:0] en,
  output logic [NP-1:0] t_q,
  output logic [NP-1:0] c_q,
  output logic oe_n_q,
  output logic fb_q,
  output logic fb_oe_n_q
);
  logic oe_n_d;
  logic fb_d;

  genvar i;
  generate
    for (i = 0; i < NP; i++) begin : g_pair
      logic hold_d;
      logic hold_q;
      logic t_d;
      logic c_d;
      logic same_phase;
      if (i < NS) begin : g_shared
        assign same_phase = sdr_mode;
      end else begin : g_ddr
        assign same_phase = 1'b0;
      end
      // The enable is only taken while the reference is low, so no runt pulse can appear except on a same-phase complement output in SDR mode.
      always_comb begin
        hold_d = ref_s ? hold_q : en[i];
        t_d = ref_s & hold_q;
        c_d = hold_q ? (same_phase ? ref_s : ~ref_s) : 1'b1;
      end
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          hold_q <= 1'b1;
          t_q[i] <= 1'b0;
          c_q[i] <= 1'b1;
        end else begin
          hold_q <= hold_d;
          t_q[i] <= t_d;
          c_q[i] <= c_d;
        end
      end
    end
  endgenerate

  always_comb begin
    oe_n_d = ~pd_n_s;
    fb_d = ref_s;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oe_n_q <= 1'b1;
      fb_q <= 1'b0;
      fb_oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= oe_n_d;
      fb_q <= fb_d;
      fb_oe_n_q <= oe_n_d;
    end
  end
endmodule : clkfo_out_gate

// ---- src/clkfo_top.sv ----
// Clock fan-out control: I2C slave, enable and drive registers, output stage.
// Assumes SDA is open drain with an external pull-up and SCL is at most a few MHz.
`timescale 1ns/10ps
module clkfo_top (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic REF_CLK_IN,
  input wire logic MODE_DDR_ONLY,
  input wire logic POWER_DOWN_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  output logic [clkfo_pkg::NUM_PAIRS-1:0] PAIR_T,
  output logic [clkfo_pkg::NUM_PAIRS-1:0] PAIR_C,
  output logic PAIR_OE_N,
  output logic FEEDBACK_CLOCK_OUT,
  output logic FEEDBACK_OE_N,
  output logic DDR_DRIVE_ENH,
  output logic SDR_DRIVE_ENH,
  output logic SDR_MODE
);
  import clkfo_pkg::*;

  logic [SYNC_W-1:0] sync_s;
  logic ref_s;
  logic sel_s;
  logic pd_s;
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  clkfo_state_t st_q;
  clkfo_state_t st_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [4:0] pos_q;
  logic [4:0] pos_d;
  logic rw_q;
  logic rw_d;
  logic nack_q;
  logic nack_d;
  logic sda_oe_n_d;
  logic wr_en;
  logic [4:0] wr_idx;

  logic [6:0] ctrl_a_q;
  logic [6:0] ctrl_a_d;
  logic [7:0] ctrl_b_q;
  logic [7:0] ctrl_b_d;
  logic ddr_enh_d;
  logic sdr_enh_d;
  logic [NUM_PAIRS-1:0] en_vec;

  clkfo_sync #(
    .W(SYNC_W),
    .RST_VAL(SYNC_IDLE)
  ) u_sync (
    .clk(MCLK),
    .rst_n(NRST),
    .async_in({REF_CLK_IN, MODE_DDR_ONLY, POWER_DOWN_N, SCL, SDA_IN}),
    .sync_out(sync_s)
  );

  assign ref_s = sync_s[4];
  assign sel_s = sync_s[3];
  assign pd_s = sync_s[2];
  assign scl_s = sync_s[1];
  assign sda_s = sync_s[0];
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_cond = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Byte presented at a given position of a read transfer.
  function automatic logic [7:0] rd_byte(input logic [4:0] pos, input logic sel,
                                         input logic [6:0] a, input logic [7:0] b);
    logic [4:0] idx;
    idx = pos - RD_DATA_OFS;
    if (pos == 5'h00) begin
      rd_byte = BYTE_COUNT_RESET;
    end else if (idx == REG_IDX_CTRL_A) begin
      rd_byte = {sel, a};
    end else if (idx == REG_IDX_CTRL_B) begin
      rd_byte = b;
    end else begin
      rd_byte = READ_FILL;
    end
  endfunction : rd_byte

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    shift_d = shift_q;
    pos_d = pos_q;
    rw_d = rw_q;
    nack_d = nack_q;
    sda_oe_n_d = SDA_OE_N;
    wr_en = 1'b0;
    wr_idx = pos_q - WR_DATA_OFS;
    if (start_cond) begin
      st_d = ST_ADDR;
      bit_d = 4'h0;
      sda_oe_n_d = 1'b1;
    end else if (stop_cond) begin
      st_d = ST_IDLE;
      sda_oe_n_d = 1'b1;
    end else begin
      case (st_q)
        ST_ADDR, ST_RX: begin
          if (scl_rise && bit_q != BITS_PER_BYTE) begin
            shift_d = {shift_q[6:0], sda_s};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == BITS_PER_BYTE) begin
            if (st_q == ST_ADDR) begin
              if (shift_q[7:1] == I2C_ADDR) begin
                st_d = ST_ACK_ADDR;
                sda_oe_n_d = 1'b0;
                rw_d = shift_q[0];
                pos_d = 5'h00;
              end else begin
                st_d = ST_IDLE;
              end
            end else begin
              // Command and count bytes are acknowledged but never stored.
              st_d = ST_ACK_RX;
              sda_oe_n_d = 1'b0;
              wr_en = (pos_q >= WR_DATA_OFS);
              if (pos_q != POS_MAX) begin
                pos_d = pos_q + 5'h01;
              end
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            if (rw_q) begin
              st_d = ST_TX;
              shift_d = rd_byte(pos_q, sel_s, ctrl_a_q, ctrl_b_q);
              sda_oe_n_d = rd_byte(pos_q, sel_s, ctrl_a_q, ctrl_b_q) >= 8'h80;
              bit_d = 4'h1;
              pos_d = pos_q + 5'h01;
            end else begin
              st_d = ST_RX;
              sda_oe_n_d = 1'b1;
            end
          end
        end
        ST_ACK_RX: begin
          if (scl_fall) begin
            st_d = ST_RX;
            bit_d = 4'h0;
            sda_oe_n_d = 1'b1;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_q == BITS_PER_BYTE) begin
              st_d = ST_ACK_TX;
              sda_oe_n_d = 1'b1;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              sda_oe_n_d = shift_q[6];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        ST_ACK_TX: begin
          if (scl_rise) begin
            nack_d = sda_s;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_d = ST_IDLE;
            end else begin
              st_d = ST_TX;
              shift_d = rd_byte(pos_q, sel_s, ctrl_a_q, ctrl_b_q);
              sda_oe_n_d = rd_byte(pos_q, sel_s, ctrl_a_q, ctrl_b_q) >= 8'h80;
              bit_d = 4'h1;
              if (pos_q != POS_MAX) begin
                pos_d = pos_q + 5'h01;
              end
            end
          end
        end
        default: begin
          st_d = ST_IDLE;
          sda_oe_n_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      pos_q <= 5'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      SDA_OE_N <= 1'b1;
      SDA_OUT <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      pos_q <= pos_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      SDA_OE_N <= sda_oe_n_d;
      SDA_OUT <= 1'b0;
    end
  end

  // Register bank and drive decode. Bit 7 of the first byte has no storage at all.
  always_comb begin
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    if (wr_en && wr_idx == REG_IDX_CTRL_A) begin
      ctrl_a_d = shift_q[6:0];
    end
    if (wr_en && wr_idx == REG_IDX_CTRL_B) begin
      ctrl_b_d = shift_q;
    end
    ddr_enh_d = ~ctrl_a_q[A_DDR_DRV_BIT];
    sdr_enh_d = ~ctrl_a_q[A_DDR_DRV_BIT] | ctrl_a_q[A_SDR_DRV_BIT];
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      ctrl_a_q <= CTRL_A_RESET;
      ctrl_b_q <= CTRL_B_RESET;
      DDR_DRIVE_ENH <= 1'b1;
      SDR_DRIVE_ENH <= 1'b1;
      SDR_MODE <= 1'b0;
    end else begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      DDR_DRIVE_ENH <= ddr_enh_d;
      SDR_DRIVE_ENH <= sdr_enh_d;
      SDR_MODE <= ~sel_s;
    end
  end

  assign en_vec = {{2{ctrl_a_q[A_PAIR1213_BIT]}}, ctrl_a_q[A_PAIR1213_BIT-1:A_PAIR8_BIT],
                   ctrl_b_q};

  clkfo_out_gate #(
    .NP(NUM_PAIRS),
    .NS(NUM_SHARED)
  ) u_gate (
    .clk(MCLK),
    .rst_n(NRST),
    .ref_s(ref_s),
    .pd_n_s(pd_s),
    .sdr_mode(~sel_s),
    .en(en_vec),
    .t_q(PAIR_T),
    .c_q(PAIR_C),
    .oe_n_q(PAIR_OE_N),
    .fb_q(FEEDBACK_CLOCK_OUT),
    .fb_oe_n_q(FEEDBACK_OE_N)
  );

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  a_addr_match: assert property ((st_q == ST_ADDR) && scl_fall && !start_cond && !stop_cond &&
    bit_q == BITS_PER_BYTE && shift_q[7:1] == I2C_ADDR |=> st_q == ST_ACK_ADDR && !SDA_OE_N)
    else $error("Own address not acknowledged.");
  a_addr_other: assert property ((st_q == ST_ADDR) && scl_fall && !start_cond && !stop_cond &&
    bit_q == BITS_PER_BYTE && shift_q[7:1] != I2C_ADDR |=> st_q == ST_IDLE && SDA_OE_N)
    else $error("Foreign address answered.");
  a_prefix_discard: assert property (st_q == ST_RX && pos_q < WR_DATA_OFS |=>
    $stable(ctrl_a_q) && $stable(ctrl_b_q))
    else $error("Command or count byte changed a register.");
  a_count_first: assert property (st_q == ST_ACK_ADDR && rw_q && scl_fall && !start_cond &&
    !stop_cond |=> shift_q == BYTE_COUNT_RESET && st_q == ST_TX)
    else $error("Read did not start with the count byte.");
  a_mode_readback: assert property (st_q == ST_ACK_TX && scl_fall && !nack_q && !start_cond &&
    !stop_cond && pos_q == REG_IDX_CTRL_A + RD_DATA_OFS |=> shift_q[7] == $past(sel_s))
    else $error("Mode pin not returned in bit 7.");
  a_drive_map: assert property (##1 (DDR_DRIVE_ENH == !$past(ctrl_a_q[A_DDR_DRV_BIT])) &&
    (SDR_DRIVE_ENH == ($past(ctrl_a_q[A_SDR_DRV_BIT]) || !$past(ctrl_a_q[A_DDR_DRV_BIT]))))
    else $error("Drive strength decode wrong.");
  a_pd_hiz: assert property (!pd_s |=> PAIR_OE_N && FEEDBACK_OE_N)
    else $error("Outputs driven during power-down.");
  a_fb_copy: assert property (pd_s |=> FEEDBACK_CLOCK_OUT == $past(ref_s) && !FEEDBACK_OE_N)
    else $error("Feedback output does not follow the reference.");
  a_nack_end: assert property (st_q == ST_ACK_TX && nack_q && scl_fall && !start_cond &&
    !stop_cond |=> st_q == ST_IDLE && SDA_OE_N)
    else $error("Read continued after a missing acknowledge.");
  a_pair_off: assert property (!en_vec[0] && !ref_s ##1 !en_vec[0] [*2] |-> !PAIR_T[0] && PAIR_C[0])
    else $error("Disabled pair not parked.");
endmodule : clkfo_top

// ---- verif/clkfo_i2c_mst.sv ----
// I2C bus master model: START, STOP, byte write with acknowledge, byte read.
// Assumes a pull-up on SDA and that tasks are entered at a falling clock edge.
`timescale 1ns/10ps
module clkfo_i2c_mst (
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  // SCL stands high between frames; each phase lasts 80 ns, so 160 ns a bit.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic start_c;
    sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
    #40;
  endtask : start_c
  task automatic stop_c;
    sda_drv = 1'b0;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #80;
  endtask : stop_c
  // Data changes 40 ns after SCL falls, well clear of the slave's hold.
  task automatic bit_tx(input logic b);
    sda_drv = b;
    #40 scl = 1'b1;
    #80 scl = 1'b0;
    #40;
  endtask : bit_tx
  task automatic bit_rx(output logic b);
    sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 b = sda_wire;
    #40 scl = 1'b0;
    #40;
  endtask : bit_rx
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_tx(d[i]);
    bit_rx(b);
    ack = !b;
  endtask : wbyte
  task automatic rbyte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) bit_rx(d[i]);
    bit_tx(last);
  endtask : rbyte
endmodule : clkfo_i2c_mst

// ---- verif/clock_fanout_output_control_tb_top.sv ----
// Testbench for the clock fan-out control block, driving it through an I2C master model.
// Assumes the package constants and a 100 MHz clock; inputs change at falling edges.
`timescale 1ns/10ps
module clock_fanout_output_control_tb_top;
  import clkfo_pkg::*;
  logic MCLK, NRST, REF_CLK_IN, MODE_DDR_ONLY, POWER_DOWN_N, SCL, SDA_OUT, SDA_OE_N;
  logic [NUM_PAIRS-1:0] PAIR_T, PAIR_C;
  logic PAIR_OE_N, FEEDBACK_CLOCK_OUT, FEEDBACK_OE_N, DDR_DRIVE_ENH, SDR_DRIVE_ENH, SDR_MODE;
  logic sda_drv, sda_wire, ack;
  int failures = 0;
  int total_checks = 0;
  int seed = 32'hffed94d8;
  logic [6:0] exp_a = CTRL_A_RESET;
  logic [7:0] exp_b = CTRL_B_RESET;
  logic [7:0] a8, b8;
  logic [7:0] rd [0:9];
  // Open-drain SDA: either party pulls low, otherwise the pull-up wins.
  assign sda_wire = sda_drv & (SDA_OE_N | SDA_OUT);
  clkfo_top u_clkfo_top (.MCLK(MCLK), .NRST(NRST), .REF_CLK_IN(REF_CLK_IN), .MODE_DDR_ONLY(MODE_DDR_ONLY),
    .POWER_DOWN_N(POWER_DOWN_N), .SCL(SCL), .SDA_IN(sda_wire), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
    .PAIR_T(PAIR_T), .PAIR_C(PAIR_C), .PAIR_OE_N(PAIR_OE_N), .FEEDBACK_CLOCK_OUT(FEEDBACK_CLOCK_OUT),
    .FEEDBACK_OE_N(FEEDBACK_OE_N), .DDR_DRIVE_ENH(DDR_DRIVE_ENH), .SDR_DRIVE_ENH(SDR_DRIVE_ENH),
    .SDR_MODE(SDR_MODE));
  clkfo_i2c_mst u_clkfo_i2c_mst (.sda_wire(sda_wire), .scl(SCL), .sda_drv(sda_drv));
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic wb(input logic [7:0] d, input logic exp_ack);
    u_clkfo_i2c_mst.wbyte(d, ack);
    chk(ack === exp_ack, "acknowledge");
  endtask : wb
  task automatic wr_regs(input logic [7:0] a, input logic [7:0] b);
    u_clkfo_i2c_mst.start_c();
    wb(8'hd2, 1'b1);
    for (int i = 0; i < 8; i++) wb(8'($random(seed)), 1'b1);
    wb(a, 1'b1);
    wb(b, 1'b1);
    u_clkfo_i2c_mst.stop_c();
  endtask : wr_regs
  task automatic chk_regs;
    u_clkfo_i2c_mst.start_c();
    wb(8'hd3, 1'b1);
    for (int i = 0; i < 10; i++) u_clkfo_i2c_mst.rbyte(rd[i], i == 9);
    u_clkfo_i2c_mst.stop_c();
    chk(rd[0] === BYTE_COUNT_RESET, "count byte");
    for (int i = 1; i < 7; i++) chk(rd[i] === READ_FILL, "unused byte");
    chk(rd[7] === {MODE_DDR_ONLY, exp_a}, "byte six");
    chk(rd[8] === exp_b, "byte seven");
    chk(rd[9] === READ_FILL, "byte eight");
    chk(DDR_DRIVE_ENH === !exp_a[5], "ddr drive");
    chk(SDR_DRIVE_ENH === (!exp_a[5] | exp_a[6]), "sdr drive");
  endtask : chk_regs
  task automatic chk_out(input logic r);
    logic [NUM_PAIRS-1:0] en;
    logic [NUM_PAIRS-1:0] c;
    en = {exp_a[4], exp_a[4:0], exp_b};
    for (int i = 0; i < NUM_PAIRS; i++) c[i] = en[i] ? ((i < NUM_SHARED && !MODE_DDR_ONLY) ? r : !r) : 1'b1;
    REF_CLK_IN = r;
    repeat (6) @(negedge MCLK);
    chk(PAIR_T === (en & {NUM_PAIRS{r}}), "true outputs");
    chk(PAIR_C === c, "complement outputs");
    chk(FEEDBACK_CLOCK_OUT === r, "feedback");
    chk(SDR_MODE === !MODE_DDR_ONLY, "mode");
    chk({PAIR_OE_N, FEEDBACK_OE_N} === 2'b00, "output enable");
  endtask : chk_out
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  initial begin
    #900000;
    failures++;
    close_out();
  end
  initial begin
    NRST = 1'b0;
    REF_CLK_IN = 1'b0;
    MODE_DDR_ONLY = 1'b1;
    POWER_DOWN_N = 1'b1;
    repeat (2) @(negedge MCLK);
    NRST = 1'b1;
    repeat (4) @(negedge MCLK);
    chk_out(1'b0);
    chk_out(1'b1);
    chk_regs();
    $display("test reset_values done");
    u_clkfo_i2c_mst.start_c();
    wb(8'hd4, 1'b0);
    u_clkfo_i2c_mst.start_c();
    wb(8'hd5, 1'b0);
    u_clkfo_i2c_mst.stop_c();
    $display("test wrong_address done");
    for (int k = 0; k < 6; k++) begin
      a8 = (k == 0) ? 8'h80 : (k == 1) ? 8'h7f : 8'($random(seed));
      b8 = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
      MODE_DDR_ONLY = (k == 0) ? 1'b0 : (k == 1) ? 1'b1 : 1'($random(seed));
      wr_regs(a8, b8);
      exp_a = a8[6:0];
      exp_b = b8;
      chk_out(1'b0);
      chk_out(1'b1);
      chk_regs();
    end
    $display("test register_writes done");
    u_clkfo_i2c_mst.start_c();
    wb(8'hd3, 1'b1);
    u_clkfo_i2c_mst.rbyte(rd[0], 1'b1);
    chk(sda_wire === 1'b1, "released after nack");
    u_clkfo_i2c_mst.stop_c();
    chk(rd[0] === BYTE_COUNT_RESET, "short read");
    $display("test early_nack done");
    POWER_DOWN_N = 1'b0;
    repeat (6) @(negedge MCLK);
    chk({PAIR_OE_N, FEEDBACK_OE_N} === 2'b11, "power down");
    POWER_DOWN_N = 1'b1;
    chk_out(1'b0);
    $display("test power_down done");
    close_out();
  end
endmodule : clock_fanout_output_control_tb_top
